/* rtl/rsq_pkg.sv */
package rsq_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int WDG_PULSE_NS    = 200;
  localparam int WDG_PULSE_CYC   =
    (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_DELAY_CYC = 514;

  // Vector map, two bytes per vector, high byte first
  localparam logic [15:0] VEC_RESET  = 16'hfffe;
  localparam logic [15:0] VEC_LOWEST = 16'hffe0;
  localparam logic [3:0]  VNUM_RESET = 4'h0;
  localparam logic [3:0]  VNUM_TRAP  = 4'h1;
  localparam logic [3:0]  VNUM_TLI   = 4'h2;
  localparam int          MAX_IRQ    = 13;

  // Condition code layout and reset values
  localparam int          CC_I1_BIT = 5;
  localparam int          CC_I0_BIT = 3;
  localparam logic [7:0]  CC_RESET  = 8'hea;
  localparam logic [15:0] SP_RESET  = 16'h01ff;

  // Priority codes {high bit, low bit}
  localparam logic [1:0] LVL0_CODE = 2'b10;
  localparam logic [1:0] LVL1_CODE = 2'b01;
  localparam logic [1:0] LVL2_CODE = 2'b00;
  localparam logic [1:0] LVL3_CODE = 2'b11;

  // Priority register file
  localparam int         NUM_PRIO_REGS = 4;
  localparam int         NUM_FIELDS    = 14;
  localparam int         FIELD_W       = 2;

  // Index of last stack frame byte (five bytes) and pin synchroniser idle value
  localparam logic [2:0] FRAME_LAST = 3'h4;
  localparam logic [4:0] SYNC_IDLE  = 5'h02;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  cc;
    logic [15:0] sp;
  } rsq_ctx_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } rsq_mem_s;

  typedef enum logic [3:0] {
    S_HOLD = 4'h0,
    S_WAIT = 4'h1,
    S_RVEC = 4'h2,
    S_RUN  = 4'h3,
    S_PUSH = 4'h4,
    S_IVEC = 4'h5,
    S_POP  = 4'h6,
    S_LOAD = 4'h7
  } rsq_state_e;

  // Code to numeric level, 0 lowest
  function automatic logic [1:0] rsqLevel(input logic [1:0] code);
    case (code)
      LVL0_CODE: rsqLevel = 2'h0;
      LVL1_CODE: rsqLevel = 2'h1;
      LVL2_CODE: rsqLevel = 2'h2;
      default:   rsqLevel = 2'h3;
    endcase
  endfunction

endpackage

/* rtl/rsq_prio_regs.sv */
`timescale 1ns/10ps
module rsq_prio_regs
  import rsq_pkg::*;
(
  // Clock
  input  wire logic                          mclk,
  input  wire logic                          srst,
  input  wire logic                          ce,
  // Write port
  input  wire logic                          wrEn,
  input  wire logic [1:0]                    wrIdx,
  input  wire logic [7:0]                    wrData,
  // Read port
  input  wire logic [1:0]                    rdIdx,
  output logic      [7:0]                    rdData_q,
  // All fields for arbitration
  output logic      [NUM_FIELDS*FIELD_W-1:0] fields_q
);

  logic [NUM_FIELDS*FIELD_W-1:0] fields_d;
  logic [7:0]                    rdData_d;
  logic [NUM_PRIO_REGS*8-1:0]    allBits;

  // Upper half of last register has no fields and reads as ones
  assign allBits = {{2{LVL3_CODE}}, fields_q};

  genvar f;
  generate
    for (f = 0; f < NUM_FIELDS; f++) begin : g_field
      localparam logic [1:0] REG_SEL = 2'(f / 4);
      localparam int         POS     = (f % 4) * FIELD_W;
      always_comb begin
        fields_d[f*FIELD_W +: FIELD_W] = fields_q[f*FIELD_W +: FIELD_W];
        // Main level cannot be stored; old value kept
        if (wrEn && wrIdx == REG_SEL &&
            wrData[POS +: FIELD_W] != LVL0_CODE) begin
          fields_d[f*FIELD_W +: FIELD_W] = wrData[POS +: FIELD_W];
        end
      end
    end
  endgenerate

  always_comb begin
    rdData_d = allBits[{rdIdx, 3'b000} +: 8];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      fields_q <= {NUM_FIELDS{LVL3_CODE}};
      rdData_q <= 8'h00;
    end else if (ce) begin
      fields_q <= fields_d;
      rdData_q <= rdData_d;
    end
  end

endmodule

/* rtl/rsq_reset_interrupt_sequencer.sv */
`timescale 1ns/10ps
module rsq_reset_interrupt_sequencer
  import rsq_pkg::*;
#(
  parameter int          NUM_IRQ     = MAX_IRQ,
  parameter int          START_DELAY = START_DELAY_CYC,
  parameter logic [15:0] SP_INIT     = SP_RESET
)
(
  // Clock
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               ce,
  // Reset sources and reset pin
  input  wire logic               oscActive,
  input  wire logic               supplyLowAsync,
  input  wire logic               supplyMonitorDisableOption,
  input  wire logic               wdgExpire,
  input  wire logic               rstPinIn,
  output logic                    rstPinOut_q,
  output logic                    rstPinOeN_q,
  // Interrupt requests
  input  wire logic [NUM_IRQ-1:0] irqReq,
  input  wire logic               topLevelInterrupt,
  input  wire logic               trapReq,
  // Core handshake
  input  wire logic               instrDone,
  input  wire logic               returnFromHandler,
  input  wire rsq_ctx_s           cpuCtx,
  output logic                    coreRun_q,
  output logic                    coreReset_q,
  output logic                    ctxLoad_q,
  output rsq_ctx_s                ctxOut_q,
  output logic                    ackStb_q,
  output logic      [3:0]         ackIdx_q,
  // Priority register access
  input  wire logic               prioWrEn,
  input  wire logic [1:0]         prioWrIdx,
  input  wire logic [7:0]         prioWrData,
  input  wire logic [1:0]         prioRdIdx,
  output logic      [7:0]         prioRdData_q,
  // Memory port
  output rsq_mem_s                memOut_q,
  input  wire logic               memAck,
  input  wire logic [7:0]         memRdata
);

  localparam int DLY_W = $clog2(START_DELAY + 1);
  localparam int WDG_W = $clog2(WDG_PULSE_CYC + 1);

  generate
    if (NUM_IRQ < 1 || NUM_IRQ > MAX_IRQ || START_DELAY < 1) begin : g_chk
      $error("rsq: NUM_IRQ or START_DELAY out of range");
    end
  endgenerate

  // Pin synchroniser: [4] osc, [3] supply low, [2] option, [1] pin, [0] tli
  logic [4:0]       syncA_q;
  logic [4:0]       syncB_q;
  logic [4:0]       pinsRaw;

  rsq_state_e       state_q;
  rsq_state_e       state_d;
  logic [2:0]       cnt_q;
  logic [2:0]       cnt_d;
  logic [DLY_W-1:0] dly_q;
  logic [DLY_W-1:0] dly_d;
  logic [WDG_W-1:0] wdgCnt_q;
  logic [WDG_W-1:0] wdgCnt_d;
  logic [15:0]      vec_q;
  logic [15:0]      vec_d;
  logic [1:0]       newPri_q;
  logic [1:0]       newPri_d;
  rsq_ctx_s         ctx_d;
  rsq_mem_s         mem_d;
  logic             ctxLoad_d;
  logic             ackStb_d;
  logic [3:0]       ackIdx_d;
  logic             rstPinOeN_d;

  logic             oscOk;
  logic             supplyLowEff;
  logic             extRst;
  logic             drivePin;
  logic             rstAny;
  logic [1:0]       curLvl;
  logic             found;
  logic [1:0]       bestLvl;
  logic [1:0]       bestCode;
  logic [3:0]       bestNum;
  logic [7:0]       pushByte;
  logic [NUM_FIELDS*FIELD_W-1:0] prioFields;

  rsq_prio_regs u_prio (
    .mclk     (mclk),
    .srst     (srst),
    .ce       (ce),
    .wrEn     (prioWrEn),
    .wrIdx    (prioWrIdx),
    .wrData   (prioWrData),
    .rdIdx    (prioRdIdx),
    .rdData_q (prioRdData_q),
    .fields_q (prioFields)
  );

  assign pinsRaw = {oscActive, supplyLowAsync, supplyMonitorDisableOption,
                    rstPinIn, topLevelInterrupt};

  // Two stages also stretch the external pulse to whole cycles
  always_ff @(posedge mclk) begin
    if (srst) begin
      syncA_q <= SYNC_IDLE;
      syncB_q <= SYNC_IDLE;
    end else if (ce) begin
      syncA_q <= pinsRaw;
      syncB_q <= syncA_q;
    end
  end

  always_comb begin
    oscOk        = syncB_q[4];
    supplyLowEff = syncB_q[3] && !syncB_q[2];
    extRst       = !syncB_q[1];
    // Internal resets pull the pin; read-back keeps the chip in reset
    drivePin     = supplyLowEff || wdgExpire || wdgCnt_q != '0;
    rstAny       = drivePin || extRst;
    // Pin stays low while the source lasts, so a blank part stays held
    rstPinOeN_d  = !drivePin;
    wdgCnt_d     = wdgCnt_q;
    if (wdgExpire) begin
      wdgCnt_d = WDG_W'(WDG_PULSE_CYC);
    end else if (wdgCnt_q != '0) begin
      wdgCnt_d = wdgCnt_q - 1'b1;
    end
  end

  // Arbiter: level from live core flags, earlier vector wins ties
  always_comb begin
    curLvl   = rsqLevel({cpuCtx.cc[CC_I1_BIT], cpuCtx.cc[CC_I0_BIT]});
    found    = 1'b0;
    bestLvl  = 2'h0;
    bestCode = LVL3_CODE;
    bestNum  = VNUM_RESET;
    for (int j = 0; j < NUM_IRQ; j++) begin
      if (irqReq[j] &&
          rsqLevel(prioFields[2*(j+1) +: 2]) > curLvl &&
          (!found || rsqLevel(prioFields[2*(j+1) +: 2]) > bestLvl)) begin
        found    = 1'b1;
        bestLvl  = rsqLevel(prioFields[2*(j+1) +: 2]);
        bestCode = prioFields[2*(j+1) +: 2];
        bestNum  = 4'(j + 3);
      end
    end
  end

  always_comb begin
    case (cnt_q)
      3'h0:    pushByte = ctxOut_q.pc[7:0];
      3'h1:    pushByte = ctxOut_q.pc[15:8];
      3'h2:    pushByte = ctxOut_q.x;
      3'h3:    pushByte = ctxOut_q.a;
      default: pushByte = ctxOut_q.cc;
    endcase
  end

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    dly_d     = dly_q;
    vec_d     = vec_q;
    newPri_d  = newPri_q;
    ctx_d     = ctxOut_q;
    mem_d     = memOut_q;
    ctxLoad_d = 1'b0;
    ackStb_d  = 1'b0;
    ackIdx_d  = ackIdx_q;
    if (rstAny) begin
      state_d   = S_HOLD;
      dly_d     = '0;
      mem_d.req = 1'b0;
    end else begin
      case (state_q)
        S_HOLD: begin
          if (oscOk) begin
            state_d = S_WAIT;
            dly_d   = '0;
          end
        end
        S_WAIT: begin
          if (!oscOk) begin
            state_d = S_HOLD;
          end else if (dly_q == DLY_W'(START_DELAY - 1)) begin
            state_d = S_RVEC;
            vec_d   = VEC_RESET;
            cnt_d   = 3'h0;
          end else begin
            dly_d = dly_q + 1'b1;
          end
        end
        S_RVEC, S_IVEC: begin
          if (!memOut_q.req) begin
            mem_d.req  = 1'b1;
            mem_d.we   = 1'b0;
            mem_d.addr = vec_q + {15'h0000, cnt_q[0]};
          end else if (memAck) begin
            mem_d.req = 1'b0;
            if (cnt_q == 3'h0) begin
              ctx_d.pc[15:8] = memRdata;
              cnt_d          = 3'h1;
            end else begin
              ctx_d.pc[7:0] = memRdata;
              state_d       = S_LOAD;
              if (state_q == S_RVEC) begin
                ctx_d.cc = CC_RESET;
                ctx_d.sp = SP_INIT;
              end
            end
          end
        end
        S_LOAD: begin
          ctxLoad_d = 1'b1;
          state_d   = S_RUN;
        end
        S_RUN: begin
          // Only sampled at an instruction boundary
          if (instrDone) begin
            cnt_d = 3'h0;
            ctx_d = cpuCtx;
            if (returnFromHandler) begin
              state_d = S_POP;
            end else if (trapReq || syncB_q[0] || found) begin
              state_d  = S_PUSH;
              ackStb_d = 1'b1;
              if (trapReq) begin
                ackIdx_d = VNUM_TRAP;
                newPri_d = LVL3_CODE;
              end else if (syncB_q[0]) begin
                ackIdx_d = VNUM_TLI;
                newPri_d = LVL3_CODE;
              end else begin
                ackIdx_d = bestNum;
                newPri_d = bestCode;
              end
              // Two bytes per vector, lower number sits higher
              vec_d = VEC_RESET - {11'h000, ackIdx_d, 1'b0};
            end
          end
        end
        S_PUSH: begin
          if (!memOut_q.req) begin
            mem_d.req   = 1'b1;
            mem_d.we    = 1'b1;
            mem_d.addr  = ctxOut_q.sp;
            mem_d.wdata = pushByte;
          end else if (memAck) begin
            mem_d.req = 1'b0;
            ctx_d.sp  = ctxOut_q.sp - 16'h0001;
            if (cnt_q == FRAME_LAST) begin
              ctx_d.cc[CC_I1_BIT] = newPri_q[1];
              ctx_d.cc[CC_I0_BIT] = newPri_q[0];
              cnt_d               = 3'h0;
              state_d             = S_IVEC;
            end else begin
              cnt_d = cnt_q + 3'h1;
            end
          end
        end
        S_POP: begin
          if (!memOut_q.req) begin
            mem_d.req  = 1'b1;
            mem_d.we   = 1'b0;
            mem_d.addr = ctxOut_q.sp + 16'h0001;
          end else if (memAck) begin
            mem_d.req = 1'b0;
            ctx_d.sp  = ctxOut_q.sp + 16'h0001;
            case (cnt_q)
              3'h0:    ctx_d.cc        = memRdata;
              3'h1:    ctx_d.a         = memRdata;
              3'h2:    ctx_d.x         = memRdata;
              3'h3:    ctx_d.pc[15:8]  = memRdata;
              default: ctx_d.pc[7:0]   = memRdata;
            endcase
            if (cnt_q == FRAME_LAST) begin
              state_d = S_LOAD;
            end else begin
              cnt_d = cnt_q + 3'h1;
            end
          end
        end
        default: state_d = S_HOLD;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q     <= S_HOLD;
      cnt_q       <= 3'h0;
      dly_q       <= '0;
      wdgCnt_q    <= '0;
      vec_q       <= VEC_RESET;
      newPri_q    <= LVL3_CODE;
      ctxOut_q    <= '0;
      memOut_q    <= '0;
      ctxLoad_q   <= 1'b0;
      ackStb_q    <= 1'b0;
      ackIdx_q    <= VNUM_RESET;
      coreRun_q   <= 1'b0;
      coreReset_q <= 1'b1;
      rstPinOut_q <= 1'b0;
      rstPinOeN_q <= 1'b1;
    end else if (ce) begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      dly_q       <= dly_d;
      wdgCnt_q    <= wdgCnt_d;
      vec_q       <= vec_d;
      newPri_q    <= newPri_d;
      ctxOut_q    <= ctx_d;
      memOut_q    <= mem_d;
      ctxLoad_q   <= ctxLoad_d;
      ackStb_q    <= ackStb_d;
      ackIdx_q    <= ackIdx_d;
      coreRun_q   <= state_d == S_RUN;
      coreReset_q <= state_d == S_HOLD || state_d == S_WAIT ||
                     state_d == S_RVEC;
      rstPinOut_q <= 1'b0;
      rstPinOeN_q <= rstPinOeN_d;
    end
  end

endmodule

/* verification/rsq_mem_model.sv */
`timescale 1ns/10ps
module rsq_mem_model
  import rsq_pkg::*;
(
  // Clock and pacing
  input  wire logic     mclk,
  input  wire logic     slow,
  // Memory port
  input  wire rsq_mem_s memOut_q,
  output logic          memAck,
  output logic [7:0]    memRdata
);
  logic [7:0] mem [0:65535];
  int         waitCnt = 0;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3c;
    end
  end
  // Idle data toggles so a stale byte never passes for a reply
  always @(posedge mclk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (memOut_q.req && !memAck) begin
      if (waitCnt < (slow ? 3 : 0)) begin
        waitCnt <= waitCnt + 1;
      end else begin
        waitCnt <= 0;
        memAck <= 1'b1;
        if (memOut_q.we) begin
          mem[memOut_q.addr] <= memOut_q.wdata;
        end else begin
          memRdata <= mem[memOut_q.addr];
        end
      end
    end
  end
endmodule

/* verification/rsq_checker.sv */
`timescale 1ns/10ps
module rsq_checker
  import rsq_pkg::*;
(
  // Clock
  input wire logic       mclk,
  input wire logic       srst,
  // Reset sources
  input wire logic       wdgExpire,
  input wire logic       supplyLowAsync,
  input wire logic       supplyMonitorDisableOption,
  input wire logic       rstPinOeN_q,
  // Core side
  input wire logic       instrDone,
  input wire logic       returnFromHandler,
  input wire logic       coreRun_q,
  input wire logic       coreReset_q,
  input wire logic       ctxLoad_q,
  input wire rsq_ctx_s   ctxOut_q,
  input wire logic       ackStb_q,
  input wire logic [3:0] ackIdx_q,
  // Memory
  input wire rsq_mem_s   memOut_q,
  input wire logic       memAck
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic        inEnt_q, inEnt_d, inRet_q, inRet_d;
  logic [3:0]  idx_q, idx_d;
  logic [15:0] vecAddr;
  logic        rd;
  // Flags tell vector, pop and boot reads apart
  always_comb begin
    inEnt_d = (inEnt_q | ackStb_q) & ~ctxLoad_q & ~coreReset_q;
    inRet_d = (inRet_q | (instrDone & returnFromHandler & coreRun_q))
              & ~ctxLoad_q & ~coreReset_q;
    idx_d = ackStb_q ? ackIdx_q : idx_q;
    vecAddr = VEC_RESET - {11'h000, idx_q, 1'b0};
    rd = memOut_q.req & ~memOut_q.we;
  end
  always_ff @(posedge mclk) begin
    inEnt_q <= srst ? 1'b0 : inEnt_d;
    inRet_q <= srst ? 1'b0 : inRet_d;
    idx_q <= idx_d;
  end
  a_wdg_pin_low:
    assert property (wdgExpire |-> ##[1:3] !rstPinOeN_q) else $error("wdg pin");
  a_supply_pin_low:
    assert property ((supplyLowAsync && !supplyMonitorDisableOption)[*4]
      |=> !rstPinOeN_q) else $error("supply pin");
  a_pin_stops_run:
    assert property (!rstPinOeN_q |-> !coreRun_q) else $error("run in reset");
  a_ack_at_end:
    assert property (ackStb_q |-> $past(instrDone) && $past(coreRun_q)
      && !coreRun_q) else $error("ack cause");
  a_unmask_level:
    assert property (ctxLoad_q && inEnt_q && idx_q < 4'h3
      |-> ctxOut_q.cc[5] && ctxOut_q.cc[3]) else $error("unmask level");
  a_vector_addr:
    assert property (rd && inEnt_q |-> memOut_q.addr[15:1] == vecAddr[15:1])
      else $error("vector addr");
  a_boot_addr:
    assert property (rd && !inEnt_q && !inRet_q
      |-> memOut_q.addr[15:1] == 15'h7fff) else $error("boot addr");
  a_req_release:
    assert property (memAck && memOut_q.req |=> !memOut_q.req)
      else $error("req held");
  a_load_pulse:
    assert property (ctxLoad_q |-> coreRun_q ##1 !ctxLoad_q)
      else $error("load pulse");
endmodule
bind rsq_reset_interrupt_sequencer rsq_checker u_chk (.mclk(mclk),
  .srst(srst), .wdgExpire(wdgExpire), .supplyLowAsync(supplyLowAsync),
  .supplyMonitorDisableOption(supplyMonitorDisableOption),
  .rstPinOeN_q(rstPinOeN_q), .instrDone(instrDone),
  .returnFromHandler(returnFromHandler), .coreRun_q(coreRun_q),
  .coreReset_q(coreReset_q), .ctxLoad_q(ctxLoad_q), .ctxOut_q(ctxOut_q),
  .ackStb_q(ackStb_q), .ackIdx_q(ackIdx_q), .memOut_q(memOut_q),
  .memAck(memAck));

/* verification/rsq_reset_interrupt_sequencer_tb.sv */
`timescale 1ns/10ps
module rsq_reset_interrupt_sequencer_tb;
  import rsq_pkg::*;
  localparam int START_D = 4;
  logic        mclk = 1'b0, srst = 1'b1, osc = 1'b1, supLow = 1'b0;
  logic        optDis = 1'b0, wdg = 1'b0, extN = 1'b1, top_level_interrupt = 1'b0;
  logic        trap = 1'b0, done = 1'b0, ret = 1'b0, slow = 1'b0;
  logic        prWe = 1'b0, pinIn, pinOut, pinOeN, run, coreRst, load;
  logic        ack, memAck;
  logic [12:0] irq = '0;
  logic [12:0] extra = '0;
  logic [1:0]  prWi = 2'h0, prRi = 2'h0;
  logic [7:0]  prWd = 8'h00, prRd, memRd;
  logic [3:0]  ackIdx;
  rsq_ctx_s    cpuCtx = '0, ctxOut;
  rsq_mem_s    memOut;
  logic [31:0] seed = 32'h00002bf3;
  logic [7:0]  prio [4] = '{default: 8'hff};
  int          miscompares = 0, nCompared = 0;
  // Pin is pulled up; either party may pull it low
  assign pinIn = extN & (pinOeN | pinOut);
  always #5 mclk = ~mclk;
  rsq_reset_interrupt_sequencer #(.START_DELAY(START_D)) u_dut (
    .mclk(mclk), .srst(srst), .ce(1'b1), .oscActive(osc),
    .supplyLowAsync(supLow), .supplyMonitorDisableOption(optDis),
    .wdgExpire(wdg), .rstPinIn(pinIn), .rstPinOut_q(pinOut),
    .rstPinOeN_q(pinOeN), .irqReq(irq), .topLevelInterrupt(top_level_interrupt),
    .trapReq(trap), .instrDone(done), .returnFromHandler(ret),
    .cpuCtx(cpuCtx), .coreRun_q(run), .coreReset_q(coreRst),
    .ctxLoad_q(load), .ctxOut_q(ctxOut), .ackStb_q(ack), .ackIdx_q(ackIdx),
    .prioWrEn(prWe), .prioWrIdx(prWi), .prioWrData(prWd),
    .prioRdIdx(prRi), .prioRdData_q(prRd), .memOut_q(memOut),
    .memAck(memAck), .memRdata(memRd));
  rsq_mem_model u_mem (.mclk(mclk), .slow(slow), .memOut_q(memOut),
    .memAck(memAck), .memRdata(memRd));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] vec(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  function automatic int lvl(input logic [1:0] c);
    return c == 2'b10 ? 0 : c == 2'b01 ? 1 : c == 2'b00 ? 2 : 3;
  endfunction
  function automatic logic [1:0] fld(input int idx);
    return prio[(idx - 2) / 4][2 * ((idx - 2) % 4)+:2];
  endfunction
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrPrio(input logic [1:0] i, input logic [7:0] d);
    prWe = 1'b1;
    prWi = i;
    prWd = d;
    tick();
    for (int f = 0; f < 4; f++) begin
      if (d[2*f+:2] != 2'b10) prio[i][2*f+:2] = d[2*f+:2];
    end
    if (i == 2'h3) prio[i][7:4] = 4'hf;
  endtask
  task automatic rdChk(input logic [1:0] i);
    prWe = 1'b0;
    prRi = i;
    tick();
    chk(prRd, prio[i]);
  endtask
  task automatic waitLoad(output int n);
    n = 0;
    while (load !== 1'b1 && n < 2000) begin
      tick();
      n++;
    end
    chk(n < 2000, 1'b1);
  endtask
  task automatic boot();
    int n;
    waitLoad(n);
    chk(n > START_D + 3, 1'b1);
    chk(ctxOut.pc, {vec(VEC_RESET), vec(VEC_RESET + 16'h1)});
    chk(ctxOut.cc, CC_RESET);
    cpuCtx = ctxOut;
    tick();
  endtask
  task automatic service(input int idx, input logic [1:0] cur);
    logic [1:0]  f;
    logic        serve;
    logic [15:0] va;
    rsq_ctx_s    sv;
    int          n;
    f = idx < 3 ? 2'b11 : fld(idx);
    serve = idx < 3 || lvl(f) > lvl(cur);
    va = VEC_RESET - 16'(2 * idx);
    sv = cpuCtx;
    {sv.pc, sv.x, sv.a} = rnd();
    sv.cc = {2'b11, cur[1], 1'b0, cur[0], 3'b000};
    cpuCtx = sv;
    top_level_interrupt = idx == 2;
    if (idx == 2) repeat (4) tick();
    irq = extra;
    if (idx > 2) irq[idx - 3] = 1'b1;
    trap = idx == 1;
    done = 1'b1;
    tick();
    done = 1'b0;
    trap = 1'b0;
    irq = '0;
    chk(ack, serve);
    if (serve) begin
      chk(ackIdx, idx);
      top_level_interrupt = 1'b0;
      waitLoad(n);
      chk(ctxOut.cc[5], f[1]);
      chk(ctxOut.cc[3], f[0]);
      chk(ctxOut.pc, {vec(va), vec(va + 16'h1)});
      cpuCtx = ctxOut;
      tick();
      ret = 1'b1;
      done = 1'b1;
      tick();
      ret = 1'b0;
      done = 1'b0;
      waitLoad(n);
      chk(ctxOut[55:16], sv[55:16]);
      cpuCtx = ctxOut;
    end
    tick();
  endtask
  task automatic final_report();
    $display("compared %0d mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    logic [31:0] r;
    int          n;
    int          ia;
    int          ib;
    repeat (12) tick();
    srst = 1'b0;
    boot();
    for (int i = 0; i < 4; i++) rdChk(2'(i));
    wrPrio(2'h0, 8'hcf);
    wrPrio(2'h0, 8'h64);
    rdChk(2'h0);
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      wrPrio(r[1:0], r[15:8]);
      rdChk(r[1:0]);
    end
    $display("test priority registers done");
    service(1, 2'b11);
    service(2, 2'b11);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      slow = r[4];
      service(1 + int'(r[31:8] % 15), r[1:0]);
    end
    // Two requests pending at once from the main level
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      slow = r[4];
      ia = 3 + int'(r[11:8] % 13);
      ib = 3 + int'(r[19:16] % 13);
      extra = '0;
      extra[ia - 3] = 1'b1;
      extra[ib - 3] = 1'b1;
      if (lvl(fld(ib)) > lvl(fld(ia)) ||
          (lvl(fld(ib)) == lvl(fld(ia)) && ib < ia)) ia = ib;
      service(ia, 2'b10);
    end
    extra = '0;
    $display("test interrupts done");
    wdg = 1'b1;
    tick();
    wdg = 1'b0;
    chk({pinOut, pinOeN}, 2'b00);
    n = 0;
    while (pinOeN === 1'b0 && n < 100) begin
      tick();
      n++;
    end
    // Expiry cycle drives the pin before the hold count starts
    chk(n, WDG_PULSE_CYC + 1);
    boot();
    optDis = 1'b1;
    repeat (4) tick();
    supLow = 1'b1;
    repeat (10) tick();
    chk({pinOeN, run}, 2'b11);
    supLow = 1'b0;
    optDis = 1'b0;
    repeat (4) tick();
    supLow = 1'b1;
    repeat (10) tick();
    chk({pinOeN, run}, 2'b00);
    supLow = 1'b0;
    boot();
    // Blank part: pin held low well past the start-up delay
    extN = 1'b0;
    repeat (40) tick();
    chk({coreRst, run, load}, 3'b100);
    extN = 1'b1;
    boot();
    extN = 1'b0;
    repeat (2) tick();
    extN = 1'b1;
    repeat (2) tick();
    chk({coreRst, run}, 2'b10);
    boot();
    $display("test reset sources done");
    final_report();
  end
endmodule
